// >>> rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

   // -----------------------------------------
   // register map
   // -----------------------------------------
   localparam int          ADDR_W                 = 8;
   localparam int          DATA_W                 = 32;
   localparam logic [7:0]  COMMAND_REGISTER_OFS   = 8'h00;
   localparam logic [7:0]  MODE_REGISTER_OFS      = 8'h04;
   localparam logic [7:0]  CHANNEL_ENABLE_SET_OFS = 8'h10;
   localparam logic [7:0]  CHANNEL_ENABLE_CLR_OFS = 8'h14;
   localparam logic [7:0]  CHANNEL_STATE_OFS      = 8'h18;
   localparam logic [7:0]  CONVERSION_STATUS_OFS  = 8'h1C;
   localparam logic [7:0]  LAST_RESULT_OFS        = 8'h20;
   localparam logic [7:0]  IRQ_ENABLE_SET_OFS     = 8'h24;
   localparam logic [7:0]  IRQ_ENABLE_CLR_OFS     = 8'h28;

   // -----------------------------------------
   // field layout
   // -----------------------------------------
   localparam int          NUM_CHANNELS           = 8;
   localparam int          RESULT_W               = 10;
   localparam int          LOW_RES_W              = 8;
   localparam int          STATUS_W               = 20;
   localparam int          SOFT_RESET_BIT         = 0;
   localparam int          START_BIT              = 1;
   localparam int          TRIG_EN_BIT            = 0;
   localparam int          TRIG_SEL_LSB           = 1;
   localparam int          LOW_RES_BIT            = 4;
   localparam int          SLEEP_BIT              = 5;
   localparam int          CLOCK_DIVIDER_FIELD_LSB            = 8;
   localparam int          CLOCK_DIVIDER_FIELD_W              = 6;
   localparam int          STARTUP_LSB            = 16;
   localparam int          STARTUP_W              = 5;
   localparam int          SAMPLE_HOLD_TIME_FIELD_LSB              = 24;
   localparam int          SAMPLE_HOLD_TIME_FIELD_W                = 4;
   localparam int          OVR_LSB                = 8;
   localparam int          RDY_BIT                = 16;
   localparam int          GOVR_BIT               = 17;
   localparam int          RECEIVE_BLOCK_END_FLAG_BIT              = 18;
   localparam int          RECEIVE_BUFFERS_EMPTY_FLAG_BIT             = 19;
   localparam logic [31:0] MODE_RESET             = 32'h00000000;
   localparam logic [31:0] MODE_WRITE_MASK        = 32'h0F1F3F3F;

   // -----------------------------------------
   // trigger codes and timing
   // -----------------------------------------
   localparam int          NUM_TRIGGERS           = 4;
   localparam logic [2:0]  TRIG_TIMER0            = 3'h0;
   localparam logic [2:0]  TRIG_TIMER1            = 3'h1;
   localparam logic [2:0]  TRIG_TIMER2            = 3'h2;
   localparam logic [2:0]  TRIG_EXTERNAL          = 3'h6;
   localparam int          EXT_TRIG_IDX           = 3;
   localparam int          STARTUP_MULT           = 8;
   localparam int          STARTUP_CNT_W          = 9;

   // -----------------------------------------
   // carriers
   // -----------------------------------------
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic       power_on;
      logic       sample;
      logic       start;
      logic       low_res;
      logic [2:0] channel;
   } conv_req_type;

   typedef struct packed {
      logic                done;
      logic [RESULT_W-1:0] result;
   } conv_rsp_type;

   typedef enum logic [3:0] {
      SEQ_IDLE    = 4'h1,
      SEQ_STARTUP = 4'h2,
      SEQ_SAMPLE  = 4'h4,
      SEQ_CONVERT = 4'h8
   } seq_state_type;

endpackage : conv_ctrl_pkg

// >>> rtl/trigger_sync.sv
module trigger_sync
   import conv_ctrl_pkg::*;
#(
   parameter int N = NUM_TRIGGERS
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic         clr,
   input  wire logic [N-1:0] pin_in,
   output logic      [N-1:0] rise
);

   // -----------------------------------------
   // three-stage sampling, agree-filtered level
   // -----------------------------------------
   logic [N-1:0] s1_q;
   logic [N-1:0] s2_q;
   logic [N-1:0] s3_q;
   logic [N-1:0] level_q;
   logic [N-1:0] rise_q;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_trig
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               s1_q[i]    <= 1'b0;
               s2_q[i]    <= 1'b0;
               s3_q[i]    <= 1'b0;
               level_q[i] <= 1'b0;
               rise_q[i]  <= 1'b0;
            end else begin
               s1_q[i] <= pin_in[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (clr) begin
                  level_q[i] <= s3_q[i];
                  rise_q[i]  <= 1'b0;
               end else begin
                  if (s2_q[i] == s3_q[i]) begin
                     level_q[i] <= s3_q[i];
                  end
                  rise_q[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level_q[i];
               end
            end
         end
      end
   endgenerate

   assign rise = rise_q;

endmodule : trigger_sync

// >>> rtl/conv_ctrl.sv
//
// Contract
// - writing one to command bit 0 resets the whole block; zero does nothing
// - writing one to the start bit begins a sequence on enabled channels
// - trigger enable 0 means software only; 1 adds the selected hardware trigger
// - trigger codes 0,1,2 pick timer outputs, code 6 the external pin
// - low resolution gives 8-bit results, upper two result bits read zero
// - sleep mode powers up on start, waits startup, converts, powers down; if set while powered, it stays on and the next start skips startup
// - hardware trigger starts a conversion on each rising edge; the code acts only on edges that arrive while the sequencer is idle
// - converter clock is master clock divided by prescaler plus one, times two
// - startup wait lasts startup field plus one, times 8, converter clocks
// - sample-hold lasts sample-hold field plus one converter clocks
// - channel state bit reads one while that channel is enabled
// - done bits read one only for enabled channels with finished conversion
// - per-channel overrun bits record overruns and clear on status read
// - result-ready sets on any result and holds until last result read
// - last result read clears result-ready and that channel's done flag
// - general overrun flags a result while ready set; status read clears
// - receive end flag sets when receive count reached zero since write
// - receive buffers empty flag is one only when both counts are zero
// - last result holds each converted value in bits 0 to 9
// - ones written to irq enable set the matching mask bits
// - ones written to irq disable clear the matching mask bits
//
// Decided for this implementation: the plain strobed port and the address map.
module conv_ctrl
   import conv_ctrl_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   input  wire reg_req_type              reg_req,
   output logic         [DATA_W-1:0]     reg_rdata,
   input  wire logic    [2:0]            timer_waveform_output_a,
   input  wire logic                     external_trigger_pin,
   output logic                          converter_clock,
   output conv_req_type                  conv_req,
   input  wire conv_rsp_type             conv_rsp,
   input  wire logic                     receive_count_zero,
   input  wire logic                     next_receive_count_zero,
   input  wire logic                     receive_count_write,
   output logic                          irq
);

   // -----------------------------------------
   // bus decode
   // -----------------------------------------
   logic soft_reset_cmd;
   logic wr_cmd;
   logic wr_mode;
   logic wr_ch_set;
   logic wr_ch_clr;
   logic wr_ie_set;
   logic wr_ie_clr;
   logic rd_status;
   logic rd_last;

   assign wr_cmd    = reg_req.wr && (reg_req.addr == COMMAND_REGISTER_OFS);
   assign wr_mode   = reg_req.wr && (reg_req.addr == MODE_REGISTER_OFS);
   assign wr_ch_set = reg_req.wr && (reg_req.addr == CHANNEL_ENABLE_SET_OFS);
   assign wr_ch_clr = reg_req.wr && (reg_req.addr == CHANNEL_ENABLE_CLR_OFS);
   assign wr_ie_set = reg_req.wr && (reg_req.addr == IRQ_ENABLE_SET_OFS);
   assign wr_ie_clr = reg_req.wr && (reg_req.addr == IRQ_ENABLE_CLR_OFS);
   assign rd_status = reg_req.rd && (reg_req.addr == CONVERSION_STATUS_OFS);
   assign rd_last   = reg_req.rd && (reg_req.addr == LAST_RESULT_OFS);

   assign soft_reset_cmd = wr_cmd && reg_req.wdata[SOFT_RESET_BIT];

   // -----------------------------------------
   // mode register fields
   // -----------------------------------------
   logic [DATA_W-1:0]    mode_q;
   logic                 hw_trigger_enable;
   logic [2:0]           trigger_source_select;
   logic                 low_resolution_select;
   logic                 sleep_select;
   logic [CLOCK_DIVIDER_FIELD_W-1:0] clock_divider_field;
   logic [STARTUP_W-1:0] startup_time_field;
   logic [SAMPLE_HOLD_TIME_FIELD_W-1:0]   sample_hold_time_field;

   assign hw_trigger_enable      = mode_q[TRIG_EN_BIT];
   assign trigger_source_select  = mode_q[TRIG_SEL_LSB +: 3];
   assign low_resolution_select  = mode_q[LOW_RES_BIT];
   assign sleep_select           = mode_q[SLEEP_BIT];
   assign clock_divider_field    = mode_q[CLOCK_DIVIDER_FIELD_LSB +: CLOCK_DIVIDER_FIELD_W];
   assign startup_time_field     = mode_q[STARTUP_LSB +: STARTUP_W];
   assign sample_hold_time_field = mode_q[SAMPLE_HOLD_TIME_FIELD_LSB +: SAMPLE_HOLD_TIME_FIELD_W];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= MODE_RESET;
      end else if (soft_reset_cmd) begin
         mode_q <= MODE_RESET;
      end else if (wr_mode) begin
         mode_q <= reg_req.wdata & MODE_WRITE_MASK;
      end
   end

   // -----------------------------------------
   // channel enable
   // -----------------------------------------
   logic [NUM_CHANNELS-1:0] channel_select_bit_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         channel_select_bit_q <= '0;
      end else if (soft_reset_cmd) begin
         channel_select_bit_q <= '0;
      end else if (wr_ch_set) begin
         channel_select_bit_q <= channel_select_bit_q | reg_req.wdata[NUM_CHANNELS-1:0];
      end else if (wr_ch_clr) begin
         channel_select_bit_q <= channel_select_bit_q & ~reg_req.wdata[NUM_CHANNELS-1:0];
      end
   end

   // -----------------------------------------
   // converter clock divider
   // -----------------------------------------
   logic [CLOCK_DIVIDER_FIELD_W-1:0] div_cnt_q;
   logic                 conv_clk_q;
   logic                 tick;

   assign tick = (div_cnt_q == clock_divider_field) && !conv_clk_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_q  <= '0;
         conv_clk_q <= 1'b0;
      end else if (soft_reset_cmd) begin
         div_cnt_q  <= '0;
         conv_clk_q <= 1'b0;
      end else if (div_cnt_q >= clock_divider_field) begin
         div_cnt_q  <= '0;
         conv_clk_q <= !conv_clk_q;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
      end
   end

   assign converter_clock = conv_clk_q;

   // -----------------------------------------
   // trigger selection
   // -----------------------------------------
   logic [NUM_TRIGGERS-1:0] trig_rise;
   logic                    hw_trig;
   logic                    sw_trig;
   logic                    start_req;

   trigger_sync #(
      .N      (NUM_TRIGGERS)
   ) u_trigger_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .clr    (soft_reset_cmd),
      .pin_in ({external_trigger_pin, timer_waveform_output_a}),
      .rise   (trig_rise)
   );

   always_comb begin
      unique case (trigger_source_select)
         TRIG_TIMER0:   hw_trig = trig_rise[0];
         TRIG_TIMER1:   hw_trig = trig_rise[1];
         TRIG_TIMER2:   hw_trig = trig_rise[2];
         TRIG_EXTERNAL: hw_trig = trig_rise[EXT_TRIG_IDX];
         default:       hw_trig = 1'b0;
      endcase
   end

   assign sw_trig   = wr_cmd && reg_req.wdata[START_BIT] && !reg_req.wdata[SOFT_RESET_BIT];
   assign start_req = sw_trig || (hw_trigger_enable && hw_trig);

   // -----------------------------------------
   // channel search
   // -----------------------------------------
   function automatic logic [3:0] next_channel(input logic [NUM_CHANNELS-1:0] en, input logic [3:0] from);
      logic [3:0] res;
      res = 4'h8;
      for (int k = NUM_CHANNELS - 1; k >= 0; k--) begin
         if (en[k] && (k >= int'(from))) begin
            res = 4'(k);
         end
      end
      return res;
   endfunction : next_channel

   // -----------------------------------------
   // conversion sequencer
   // -----------------------------------------
   seq_state_type          state_q;
   logic [2:0]             chan_q;
   logic [STARTUP_CNT_W-1:0] wait_q;
   logic                   power_q;
   logic                   start_q;
   logic [3:0]             first_ch;
   logic [3:0]             next_ch;
   logic                   result_done;

   assign first_ch    = next_channel(channel_select_bit_q, 4'h0);
   assign next_ch     = next_channel(channel_select_bit_q, {1'b0, chan_q} + 4'h1);
   assign result_done = (state_q == SEQ_CONVERT) && conv_rsp.done;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= SEQ_IDLE;
         chan_q  <= '0;
         wait_q  <= '0;
         power_q <= 1'b0;
         start_q <= 1'b0;
      end else if (soft_reset_cmd) begin
         state_q <= SEQ_IDLE;
         chan_q  <= '0;
         wait_q  <= '0;
         power_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         unique case (state_q)
            SEQ_IDLE: begin
               if (!sleep_select && power_q) begin
                  power_q <= 1'b1;
               end
               if (start_req && !first_ch[3]) begin
                  chan_q  <= first_ch[2:0];
                  power_q <= 1'b1;
                  // entry is not tick aligned: one extra tick keeps the full span
                  if (power_q) begin
                     wait_q  <= STARTUP_CNT_W'(sample_hold_time_field) + STARTUP_CNT_W'(1);
                     state_q <= SEQ_SAMPLE;
                  end else begin
                     wait_q  <= STARTUP_CNT_W'((startup_time_field + 6'h1) * STARTUP_MULT);
                     state_q <= SEQ_STARTUP;
                  end
               end
            end
            SEQ_STARTUP: begin
               if (tick) begin
                  if (wait_q == '0) begin
                     wait_q  <= STARTUP_CNT_W'(sample_hold_time_field);
                     state_q <= SEQ_SAMPLE;
                  end else begin
                     wait_q <= wait_q - 1'b1;
                  end
               end
            end
            SEQ_SAMPLE: begin
               if (tick) begin
                  if (wait_q == '0) begin
                     start_q <= 1'b1;
                     state_q <= SEQ_CONVERT;
                  end else begin
                     wait_q <= wait_q - 1'b1;
                  end
               end
            end
            SEQ_CONVERT: begin
               if (conv_rsp.done) begin
                  if (next_ch[3]) begin
                     power_q <= !sleep_select;
                     state_q <= SEQ_IDLE;
                  end else begin
                     chan_q  <= next_ch[2:0];
                     wait_q  <= STARTUP_CNT_W'(sample_hold_time_field) + STARTUP_CNT_W'(1);
                     state_q <= SEQ_SAMPLE;
                  end
               end
            end
         endcase
      end
   end

   assign conv_req.power_on = power_q;
   assign conv_req.sample   = (state_q == SEQ_SAMPLE);
   assign conv_req.start    = start_q;
   assign conv_req.low_res  = low_resolution_select;
   assign conv_req.channel  = chan_q;

   // -----------------------------------------
   // result and flags
   // -----------------------------------------
   logic [RESULT_W-1:0]     last_result_value_q;
   logic [2:0]              last_ch_q;
   logic [NUM_CHANNELS-1:0] conversion_done_flag_q;
   logic [NUM_CHANNELS-1:0] channel_overrun_flag_q;
   logic                    result_ready_flag_q;
   logic                    any_overrun_flag_q;
   logic                    receive_block_end_flag_q;
   logic                    receive_buffers_empty_flag;
   logic [NUM_CHANNELS-1:0] done_set;
   logic [NUM_CHANNELS-1:0] done_clr;

   assign done_set = result_done ? (NUM_CHANNELS'(1) << chan_q) : '0;
   assign done_clr = rd_last ? (NUM_CHANNELS'(1) << last_ch_q) : '0;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         last_result_value_q <= '0;
         last_ch_q           <= '0;
      end else if (soft_reset_cmd) begin
         last_result_value_q <= '0;
         last_ch_q           <= '0;
      end else if (result_done) begin
         last_ch_q <= chan_q;
         if (low_resolution_select) begin
            last_result_value_q <= {2'b00, conv_rsp.result[LOW_RES_W-1:0]};
         end else begin
            last_result_value_q <= conv_rsp.result;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conversion_done_flag_q <= '0;
         channel_overrun_flag_q <= '0;
         result_ready_flag_q    <= 1'b0;
         any_overrun_flag_q     <= 1'b0;
      end else if (soft_reset_cmd) begin
         conversion_done_flag_q <= '0;
         channel_overrun_flag_q <= '0;
         result_ready_flag_q    <= 1'b0;
         any_overrun_flag_q     <= 1'b0;
      end else begin
         conversion_done_flag_q <= (conversion_done_flag_q & ~done_clr) | done_set;
         channel_overrun_flag_q <= (channel_overrun_flag_q & ~{NUM_CHANNELS{rd_status}})
                                   | (done_set & conversion_done_flag_q);
         result_ready_flag_q    <= (result_ready_flag_q && !rd_last) || result_done;
         any_overrun_flag_q     <= (any_overrun_flag_q && !rd_status)
                                   || (result_done && result_ready_flag_q);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         receive_block_end_flag_q <= 1'b0;
      end else if (soft_reset_cmd) begin
         receive_block_end_flag_q <= 1'b0;
      end else begin
         receive_block_end_flag_q <= (receive_block_end_flag_q && !receive_count_write)
                                     || receive_count_zero;
      end
   end

   assign receive_buffers_empty_flag = receive_count_zero && next_receive_count_zero;

   // -----------------------------------------
   // status word and interrupt
   // -----------------------------------------
   logic [STATUS_W-1:0] status;
   logic [STATUS_W-1:0] irq_mask_q;

   always_comb begin
      status                          = '0;
      status[NUM_CHANNELS-1:0]        = conversion_done_flag_q & channel_select_bit_q;
      status[OVR_LSB +: NUM_CHANNELS] = channel_overrun_flag_q;
      status[RDY_BIT]                 = result_ready_flag_q;
      status[GOVR_BIT]                = any_overrun_flag_q;
      status[RECEIVE_BLOCK_END_FLAG_BIT]               = receive_block_end_flag_q;
      status[RECEIVE_BUFFERS_EMPTY_FLAG_BIT]              = receive_buffers_empty_flag;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_q <= '0;
      end else if (soft_reset_cmd) begin
         irq_mask_q <= '0;
      end else if (wr_ie_set) begin
         irq_mask_q <= irq_mask_q | reg_req.wdata[STATUS_W-1:0];
      end else if (wr_ie_clr) begin
         irq_mask_q <= irq_mask_q & ~reg_req.wdata[STATUS_W-1:0];
      end
   end

   assign irq = |(status & irq_mask_q);

   // -----------------------------------------
   // read data
   // -----------------------------------------
   logic [DATA_W-1:0] rdata_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else if (reg_req.rd) begin
         unique case (reg_req.addr)
            MODE_REGISTER_OFS:     rdata_q <= mode_q;
            CHANNEL_STATE_OFS:     rdata_q <= DATA_W'(channel_select_bit_q);
            CONVERSION_STATUS_OFS: rdata_q <= DATA_W'(status);
            LAST_RESULT_OFS:       rdata_q <= DATA_W'(last_result_value_q);
            default:               rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : conv_ctrl

// >>> test/conv_model.sv
module conv_model
   import conv_ctrl_pkg::*;
#(
   parameter int LAT = 4
) (
   input  wire logic         mclk,
   input  wire conv_req_type conv_req,
   output conv_rsp_type      conv_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   int         cnt_q = 0;
   logic [2:0] ch_q  = 3'h0;
   initial conv_rsp = '0;
   // result only valid beside done; toggles otherwise
   always @(posedge mclk) begin
      conv_rsp.done   <= cnt_q == 1;
      conv_rsp.result <= (cnt_q == 1) ? {ch_q, 7'h5A} & (conv_req.low_res ? 10'h0FF : 10'h3FF) : ~conv_rsp.result;
      cnt_q           <= (conv_req.start && conv_req.power_on) ? LAT : cnt_q - 32'(cnt_q != 0);
      ch_q            <= conv_req.start ? conv_req.channel : ch_q;
   end
endmodule : conv_model

// >>> test/conv_ctrl_properties.sv
module conv_ctrl_properties
   import conv_ctrl_pkg::*;
(
   input wire logic              mclk,
   input wire logic              resetn,
   input wire reg_req_type       reg_req,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire conv_req_type      conv_req,
   input wire conv_rsp_type      conv_rsp,
   input wire logic              receive_count_zero,
   input wire logic              next_receive_count_zero
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic rd_st, rd_lr;
   assign rd_st = reg_req.rd && reg_req.addr == CONVERSION_STATUS_OFS;
   assign rd_lr = reg_req.rd && reg_req.addr == LAST_RESULT_OFS;
   a_start_powered: assert property (conv_req.start |-> conv_req.power_on) else $error("unpowered");
   a_sample_span: assert property ($rose(conv_req.sample) |=> conv_req.sample) else $error("short hold");
   a_low_res_data:
      assert property (rd_lr && conv_req.low_res |=> reg_rdata[DATA_W-1:LOW_RES_W] == '0) else $error("low res");
   a_result_width: assert property (rd_lr |=> reg_rdata[DATA_W-1:RESULT_W] == '0) else $error("wide");
   a_chstate_width:
      assert property (reg_req.rd && reg_req.addr == CHANNEL_STATE_OFS |=> reg_rdata[31:8] == '0) else $error("ch");
   a_overrun_clear:
      assert property (!conv_rsp.done [*2] ##1 (rd_st && !conv_rsp.done) ##1 !conv_rsp.done ##1 rd_st
         |=> reg_rdata[15:8] == '0 && !reg_rdata[GOVR_BIT]) else $error("overrun kept");
   a_rx_empty:
      assert property (rd_st && $stable(receive_count_zero) && $stable(next_receive_count_zero) |=>
         reg_rdata[RECEIVE_BUFFERS_EMPTY_FLAG_BIT] == ($past(receive_count_zero) && $past(next_receive_count_zero))) else $error("rx");
   a_soft_reset:
      assert property (reg_req.wr && reg_req.addr == 8'h00 && reg_req.wdata[0] |=> !conv_req.power_on)
         else $error("soft reset");
   c_done: cover property (conv_rsp.done);
   c_sample: cover property ($fell(conv_req.sample));
   c_power_down: cover property ($fell(conv_req.power_on));
endmodule : conv_ctrl_properties

bind conv_ctrl conv_ctrl_properties i_props (.mclk, .resetn, .reg_req, .reg_rdata, .conv_req, .conv_rsp,
   .receive_count_zero, .next_receive_count_zero);

// >>> test/tb.sv
module tb
   import conv_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              mclk = 1'b0, resetn = 1'b0, rcz = 1'b0, nrcz = 1'b0, rcw = 1'b1, cclk, irq;
   logic [3:0]        trg = 4'h0;
   logic [DATA_W-1:0] rdata;
   reg_req_type       req = '0;
   conv_req_type      creq;
   conv_rsp_type      crsp;
   int                fail_count = 0, n_compared = 0;
   time               t0;
   // trigger cases: hit, pins, mode low nibble
   logic [8:0]        trg_t [7] = '{9'h111, 9'h123, 9'h145, 9'h18D, 9'h0F7, 9'h0F0, 9'h0E1};
   always #50 mclk = ~mclk;
   conv_ctrl i_dut (.mclk(mclk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata), .irq(irq),
      .timer_waveform_output_a(trg[2:0]), .external_trigger_pin(trg[3]), .converter_clock(cclk),
      .conv_req(creq), .conv_rsp(crsp), .receive_count_zero(rcz), .next_receive_count_zero(nrcz),
      .receive_count_write(rcw));
   conv_model i_model (.mclk(mclk), .conv_req(creq), .conv_rsp(crsp));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %h, want %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask : wr
   task rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge mclk);
      req.rd <= 1'b0;
      @(negedge mclk);
      chk(rdata, exp);
   endtask : rchk
   task conv(input logic sw, input logic exp);
      int k;
      if (sw)
         wr(COMMAND_REGISTER_OFS, 32'h2);
      for (k = 0; k < 3000 && crsp.done !== 1'b1; k++)
         @(posedge mclk);
      chk(32'(k < 3000), 32'(exp));
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask : conv
   task stop_test;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      rcw <= 1'b0;
      rchk(MODE_REGISTER_OFS, MODE_RESET);
      wr(MODE_REGISTER_OFS, 32'hFFFFFFFF);
      rchk(MODE_REGISTER_OFS, MODE_WRITE_MASK);
      wr(MODE_REGISTER_OFS, 32'h0);
      rchk(8'h08, 32'h0);
      wr(CHANNEL_ENABLE_SET_OFS, 32'h81);
      wr(CHANNEL_ENABLE_CLR_OFS, 32'h01); // takes effect in any sequencer state
      rchk(CHANNEL_STATE_OFS, 32'h80);
      wr(IRQ_ENABLE_SET_OFS, 32'h10000);
      conv(1'b1, 1'b1);
      chk(32'(irq), 32'h1);
      rchk(CONVERSION_STATUS_OFS, 32'h10080);
      rchk(LAST_RESULT_OFS, 32'h3DA);
      rchk(CONVERSION_STATUS_OFS, 32'h0);
      conv(1'b1, 1'b1);
      conv(1'b1, 1'b1);
      rchk(CONVERSION_STATUS_OFS, 32'h38080);
      rchk(CONVERSION_STATUS_OFS, 32'h10080);
      wr(IRQ_ENABLE_CLR_OFS, 32'h10000);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      wr(MODE_REGISTER_OFS, 32'h10);
      conv(1'b1, 1'b1);
      rchk(LAST_RESULT_OFS, 32'hDA);
      for (int i = 0; i < 7; i++) begin
         wr(MODE_REGISTER_OFS, {28'h0, trg_t[i][3:0]});
         trg <= trg_t[i][7:4];
         conv(1'b0, trg_t[i][8]);
         trg <= 4'h0;
      end
      wr(MODE_REGISTER_OFS, 32'h20);
      conv(1'b1, 1'b1);
      chk(32'(creq.power_on), 32'h0);
      wr(MODE_REGISTER_OFS, 32'h300);
      repeat (2) @(posedge cclk);
      t0 = $time;
      @(posedge cclk);
      chk(32'(($time - t0) / 100), 32'h8);
      wr(COMMAND_REGISTER_OFS, 32'h3);
      rchk(MODE_REGISTER_OFS, 32'h0);
      rchk(CHANNEL_STATE_OFS, 32'h0);
      @(posedge mclk);
      rcz <= 1'b1;
      nrcz <= 1'b1;
      rchk(CONVERSION_STATUS_OFS, 32'hC0000);
      rcz <= 1'b0;
      rcw <= 1'b1;
      @(posedge mclk);
      rcw <= 1'b0;
      rchk(CONVERSION_STATUS_OFS, 32'h0);
      stop_test();
   end
   initial begin
      #6000000;
      fail_count++;
      stop_test();
   end
endmodule : tb
